// [shared/lgp_pkg.sv]
package lgp_pkg;
    localparam int unsigned CH_NUM     = 16;
    localparam int unsigned GS_W       = 12;
    localparam int unsigned DC_W       = 6;
    localparam int unsigned CNT_W      = 13;
    localparam logic [12:0] CNT_END    = 13'h1000;
    localparam logic [5:0]  EE_DEFAULT = 6'h3f;
    localparam logic [5:0]  DC_RESET   = 6'h00;
    localparam int unsigned SYNC_W     = 9;

    // Register byte offsets.
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h000;
    localparam logic [11:0] OFS_IRQ_MASK   = 12'h004;
    localparam logic [11:0] OFS_CTRL       = 12'h008;
    localparam logic [11:0] OFS_STATE      = 12'h00c;
    localparam logic [11:0] OFS_LOD_STATUS = 12'h010;

    // Interrupt status and mask bit positions.
    localparam int unsigned IRQ_LOD_BIT   = 0;
    localparam int unsigned IRQ_TEF_BIT   = 1;
    localparam int unsigned IRQ_LATCH_BIT = 2;
    localparam int unsigned IRQ_END_BIT   = 3;
    localparam int unsigned IRQ_W         = 4;

    // Control register bits.
    localparam int unsigned CTRL_SOFT_OFF_BIT = 0;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
    localparam logic [3:0]  MASK_RESET        = 4'h0;

    // State register field positions.
    localparam int unsigned ST_CNT_LSB  = 0;
    localparam int unsigned ST_TEF_BIT  = 13;
    localparam int unsigned ST_MODE_BIT = 14;
    localparam int unsigned ST_ERR_BIT  = 15;
    localparam int unsigned ST_SRC_BIT  = 16;
endpackage

// [shared/lgp_pwm_if.sv]
`timescale 1ns/1ns
interface lgp_pwm_if;
    logic [12:0] count;
    logic        blank;
    modport ctrl (output count, output blank);
    modport chan (input count, input blank);
endinterface

// [design/lgp_channel.sv]
`timescale 1ns/1ns
module lgp_channel #(
    parameter int unsigned GS_W = lgp_pkg::GS_W
) (
    input  wire logic            clk_sys,
    input  wire logic            rst,
    lgp_pwm_if.chan              pwm,
    input  wire logic [GS_W-1:0] gs_value,
    output logic                 sink_on
);
    logic sink_on_ff;

    if (GS_W + 1 != lgp_pkg::CNT_W) begin : g_chk
        $error("GS_W must be one bit narrower than the shared PWM count");
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sink_on_ff <= 1'b0;
        end else begin
            sink_on_ff <= !pwm.blank && (pwm.count < {1'b0, gs_value});
        end
    end

    assign sink_on = sink_on_ff;
endmodule

// [design/lgp_eeprom.sv]
`timescale 1ns/1ns
module lgp_eeprom #(
    parameter int unsigned WORDS = lgp_pkg::CH_NUM,
    parameter int unsigned DW    = lgp_pkg::DC_W
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                wr_en,
    input  wire logic [WORDS*DW-1:0] wr_data,
    output logic      [WORDS*DW-1:0] rd_data
);
    logic [WORDS*DW-1:0] mem_ff;
    logic [WORDS*DW-1:0] rd_ff;

    if (WORDS < 1 || DW < 1) begin : g_chk
        $error("WORDS and DW must both be at least 1");
    end

    // The cells model non-volatile storage; the reset stands in for an
    // unprogrammed part, so every word starts at full scale.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_ff <= {WORDS{lgp_pkg::EE_DEFAULT}};
        end else if (wr_en) begin
            mem_ff <= wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_ff <= {WORDS{lgp_pkg::EE_DEFAULT}};
        end else begin
            rd_ff <= mem_ff;
        end
    end

    assign rd_data = rd_ff;
endmodule

// [design/lgp_driver.sv]
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
// Summary of operation
// - High force-off input turns every sink output off regardless of settings.
// - High force-off input also clears the grayscale counter to zero.
// - With force-off low and the soft-off control bit clear, each output follows its grayscale PWM comparison.
// - Correction source low selects EEPROM values, high selects the register.
// - Programming level with source select high copies register into EEPROM.
// - Unprogrammed EEPROM words read as full scale 3Fh.
// - Mode select low means grayscale mode, high means dot-correction mode.
// - Latch strobe high copies shift register transparently into the mode's register.
// - Latch strobe low holds both data registers unchanged.
// - Error output pulled low while overtemperature is active, or while open LED is active and outputs are not blanked.
// - The grayscale counter advances on the separate PWM reference clock.
// - Host shifts serial data in; device shifts it through to serial out.
// - Serial input captured on each shift clock rise, words sent MSB first.
// - Falling latch strobe captures per-channel open-LED bits into status.
module lgp_driver #(
    parameter int unsigned CHANNELS = lgp_pkg::CH_NUM
) (
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    input  wire logic [11:0]                       paddr,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    output logic                                   irq,
    input  wire logic                              shift_clock,
    input  wire logic                              serial_in,
    output logic                                   serial_out,
    input  wire logic                              latch_strobe,
    input  wire logic                              program_mode_sel,
    input  wire logic                              program_level,
    input  wire logic                              correction_source_sel,
    input  wire logic                              output_off_force,
    input  wire logic                              pwm_ref_clock,
    input  wire logic [CHANNELS-1:0]               open_led_detect,
    input  wire logic                              overtemp_flag,
    output logic      [CHANNELS-1:0]               sink_output,
    output logic      [CHANNELS*lgp_pkg::DC_W-1:0] dot_correction,
    output logic                                   error_flag_n_o,
    output logic                                   error_flag_n_oe
);
    localparam int unsigned GSL = CHANNELS * lgp_pkg::GS_W;
    localparam int unsigned DCL = CHANNELS * lgp_pkg::DC_W;
    localparam int unsigned AW  = lgp_pkg::SYNC_W + CHANNELS;

    if (CHANNELS < 1 || CHANNELS > 16) begin : g_chk
        $error("CHANNELS must lie between 1 and 16");
    end

    // Pin synchronisers: every pin passes two flops before any logic.
    logic [AW-1:0] sync1_ff;
    logic [AW-1:0] sync2_ff;
    logic [2:0]    prev_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {open_led_detect, overtemp_flag, pwm_ref_clock, output_off_force,
                         correction_source_sel, program_level, program_mode_sel,
                         latch_strobe, serial_in, shift_clock};
            sync2_ff <= sync1_ff;
        end
    end

    // Shift clock, latch strobe and PWM clock keep a third stage here; the interrupt edge flops sit below, so no flop goes unread.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_ff <= 3'h0;
        end else begin
            prev_ff <= {sync2_ff[7], sync2_ff[2], sync2_ff[0]};
        end
    end

    logic                sclk_s;
    logic                sin_s;
    logic                latch_s;
    logic                mode_s;
    logic                plvl_s;
    logic                csel_s;
    logic                force_s;
    logic                tef_s;
    logic [CHANNELS-1:0] lod_s;
    logic                sclk_rise;
    logic                latch_fall;
    logic                pwm_rise;

    assign sclk_s     = sync2_ff[0];
    assign sin_s      = sync2_ff[1];
    assign latch_s    = sync2_ff[2];
    assign mode_s     = sync2_ff[3];
    assign plvl_s     = sync2_ff[4];
    assign csel_s     = sync2_ff[5];
    assign force_s    = sync2_ff[6];
    assign tef_s      = sync2_ff[8];
    assign lod_s      = sync2_ff[AW-1:lgp_pkg::SYNC_W];
    assign sclk_rise  = sync2_ff[0] && !prev_ff[0];
    assign latch_fall = !sync2_ff[2] && prev_ff[1];
    assign pwm_rise   = sync2_ff[7] && !prev_ff[2];

    // Software registers.
    logic [lgp_pkg::IRQ_W-1:0] irq_status_ff;
    logic [lgp_pkg::IRQ_W-1:0] irq_mask_ff;
    logic [31:0]               ctrl_ff;
    logic                      blank;

    assign blank = force_s || ctrl_ff[lgp_pkg::CTRL_SOFT_OFF_BIT];

    // Input shift register: grayscale mode uses the whole length, dot-correction
    // mode only the low part, so serial out taps the end of the active frame.
    logic [GSL-1:0] sr_ff;
    logic           serial_out_ff;
    // A shift takes priority over a status load in the same cycle; the host must
    // not clock data while the strobe falls, or that status word is lost.

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sr_ff <= '0;
        end else if (sclk_rise) begin
            sr_ff <= {sr_ff[GSL-2:0], sin_s};
        end else if (latch_fall && !mode_s) begin
            // Status goes to the head of the frame so it leaves first.
            sr_ff <= {lod_s, tef_s, sr_ff[GSL-CHANNELS-2:0]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serial_out_ff <= 1'b0;
        end else begin
            serial_out_ff <= mode_s ? sr_ff[DCL-1] : sr_ff[GSL-1];
        end
    end

    assign serial_out = serial_out_ff;

    // Each data register is transparent while the strobe stays high and its own mode is selected.
    logic [GSL-1:0] gs_reg_ff;
    logic [DCL-1:0] dc_reg_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gs_reg_ff <= '0;
        end else if (latch_s && !mode_s) begin
            gs_reg_ff <= sr_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dc_reg_ff <= {CHANNELS{lgp_pkg::DC_RESET}};
        end else if (latch_s && mode_s) begin
            dc_reg_ff <= sr_ff[DCL-1:0];
        end
    end

    // Open-LED status captured at the end of each strobe pulse.
    logic [CHANNELS-1:0] lod_status_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lod_status_ff <= '0;
        end else if (latch_fall) begin
            lod_status_ff <= lod_s;
        end
    end

    // Grayscale counter. It parks at its end so that a late latch or a slow
    // host never wraps into a second, unrequested cycle.
    logic [lgp_pkg::CNT_W-1:0] cnt_ff;
    logic                      cycle_end;

    assign cycle_end = pwm_rise && !blank && (cnt_ff == lgp_pkg::CNT_END - 13'h0001);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (blank) begin
            cnt_ff <= '0;
        end else if (pwm_rise && cnt_ff != lgp_pkg::CNT_END) begin
            cnt_ff <= cnt_ff + 13'h0001;
        end
    end

    lgp_pwm_if pwm_bus ();

    assign pwm_bus.count = cnt_ff;
    assign pwm_bus.blank = blank;

    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        lgp_channel #(
            .GS_W (lgp_pkg::GS_W)
        ) u_ch (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .pwm      (pwm_bus.chan),
            .gs_value (gs_reg_ff[i*lgp_pkg::GS_W +: lgp_pkg::GS_W]),
            .sink_on  (sink_output[i])
        );
    end

    // Dot correction source and EEPROM programming.
    logic           ee_we;
    logic [DCL-1:0] ee_q;
    logic [DCL-1:0] dc_out_ff;

    assign ee_we = plvl_s && csel_s;

    lgp_eeprom #(
        .WORDS (CHANNELS),
        .DW    (lgp_pkg::DC_W)
    ) u_ee (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (ee_we),
        .wr_data (dc_reg_ff),
        .rd_data (ee_q)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dc_out_ff <= {CHANNELS{lgp_pkg::EE_DEFAULT}};
        end else begin
            dc_out_ff <= csel_s ? dc_reg_ff : ee_q;
        end
    end

    assign dot_correction = dc_out_ff;

    // Error pin: open drain, so only the low level is ever driven. Open-LED
    // errors are hidden while blanked, since the sinks are off then anyway.
    logic err_oe_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            err_oe_ff <= 1'b0;
        end else begin
            err_oe_ff <= tef_s || ((|lod_s) && !blank);
        end
    end

    assign error_flag_n_o  = 1'b0;
    assign error_flag_n_oe = err_oe_ff;

    // APB slave: zero wait states, read data prepared in the setup cycle.
    // A live field such as the counter therefore reads as it stood at the setup
    // edge; registering the data keeps prdata steady through the access phase.
    logic        wr_acc;
    logic        rd_setup;
    logic        mapped;
    logic [31:0] rd_mux;
    logic [31:0] prdata_ff;
    logic        tef_prev_ff;
    logic        lod_any_prev_ff;
    logic [lgp_pkg::IRQ_W-1:0] ev;
    logic [lgp_pkg::IRQ_W-1:0] w1c;

    assign mapped   = (paddr == lgp_pkg::OFS_IRQ_STATUS) || (paddr == lgp_pkg::OFS_IRQ_MASK)
                   || (paddr == lgp_pkg::OFS_CTRL) || (paddr == lgp_pkg::OFS_STATE)
                   || (paddr == lgp_pkg::OFS_LOD_STATUS);
    assign wr_acc   = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            lgp_pkg::OFS_IRQ_STATUS: rd_mux[lgp_pkg::IRQ_W-1:0] = irq_status_ff;
            lgp_pkg::OFS_IRQ_MASK:   rd_mux[lgp_pkg::IRQ_W-1:0] = irq_mask_ff;
            lgp_pkg::OFS_CTRL:       rd_mux = ctrl_ff;
            lgp_pkg::OFS_STATE: begin
                rd_mux[lgp_pkg::ST_CNT_LSB +: lgp_pkg::CNT_W] = cnt_ff;
                rd_mux[lgp_pkg::ST_TEF_BIT]  = tef_s;
                rd_mux[lgp_pkg::ST_MODE_BIT] = mode_s;
                rd_mux[lgp_pkg::ST_ERR_BIT]  = err_oe_ff;
                rd_mux[lgp_pkg::ST_SRC_BIT]  = csel_s;
            end
            lgp_pkg::OFS_LOD_STATUS: rd_mux[CHANNELS-1:0] = lod_status_ff;
            default:                 rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_ff <= rd_mux;
        end
    end

    assign prdata = prdata_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_ff     <= lgp_pkg::CTRL_RESET;
            irq_mask_ff <= lgp_pkg::MASK_RESET;
        end else if (wr_acc && paddr == lgp_pkg::OFS_CTRL) begin
            ctrl_ff <= {31'h0000_0000, pwdata[lgp_pkg::CTRL_SOFT_OFF_BIT]};
        end else if (wr_acc && paddr == lgp_pkg::OFS_IRQ_MASK) begin
            irq_mask_ff <= pwdata[lgp_pkg::IRQ_W-1:0];
        end
    end

    // Interrupt events; a new event in the clearing cycle survives the clear.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tef_prev_ff     <= 1'b0;
            lod_any_prev_ff <= 1'b0;
        end else begin
            tef_prev_ff     <= tef_s;
            lod_any_prev_ff <= |lod_s;
        end
    end

    always_comb begin
        ev = '0;
        ev[lgp_pkg::IRQ_LOD_BIT]   = (|lod_s) && !lod_any_prev_ff;
        ev[lgp_pkg::IRQ_TEF_BIT]   = tef_s && !tef_prev_ff;
        ev[lgp_pkg::IRQ_LATCH_BIT] = latch_fall;
        ev[lgp_pkg::IRQ_END_BIT]   = cycle_end;
        w1c = (wr_acc && paddr == lgp_pkg::OFS_IRQ_STATUS) ? pwdata[lgp_pkg::IRQ_W-1:0] : '0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_status_ff <= '0;
        end else begin
            irq_status_ff <= (irq_status_ff & ~w1c) | ev;
        end
    end

    assign irq = |(irq_status_ff & irq_mask_ff);
endmodule

// [tb/lgp_driver_monitor.sv]
`timescale 1ns/1ns
module lgp_driver_mon #(
    parameter int unsigned CHANNELS = lgp_pkg::CH_NUM
) (
    input wire logic                              clk_sys,
    input wire logic                              rst,
    input wire logic [11:0]                       paddr,
    input wire logic                              psel,
    input wire logic                              penable,
    input wire logic                              pready,
    input wire logic                              pslverr,
    input wire logic                              shift_clock,
    input wire logic                              serial_out,
    input wire logic                              latch_strobe,
    input wire logic                              program_mode_sel,
    input wire logic                              correction_source_sel,
    input wire logic                              output_off_force,
    input wire logic [CHANNELS-1:0]               open_led_detect,
    input wire logic                              overtemp_flag,
    input wire logic [CHANNELS-1:0]               sink_output,
    input wire logic [CHANNELS*lgp_pkg::DC_W-1:0] dot_correction,
    input wire logic                              error_flag_n_o,
    input wire logic                              error_flag_n_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Repetition counts leave room for the two-stage pin synchroniser and the output register.
    a_force_all_off: assert property (output_off_force [*5] |-> sink_output == '0)
        else $error("outputs on while forced off");
    a_err_overtemp: assert property (overtemp_flag [*5] |-> error_flag_n_oe)
        else $error("error pin not pulled on overtemperature");
    a_err_release: assert property ((!overtemp_flag && open_led_detect == '0) [*5] |-> !error_flag_n_oe)
        else $error("error pin pulled without a fault");
    a_drain_low: assert property (error_flag_n_oe |-> error_flag_n_o == 1'b0)
        else $error("error pin driven high");
    a_serial_quiet: assert property ((!shift_clock && !latch_strobe && $stable(program_mode_sel)) [*7]
        |-> $stable(serial_out))
        else $error("serial output moved without a shift");
    a_dc_held: assert property ((!latch_strobe && correction_source_sel) [*6] |-> $stable(dot_correction))
        else $error("correction changed while latch low");
    a_apb_err_map: assert property (psel && penable
        |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010}))
        else $error("slave error does not match address map");
    a_apb_no_wait: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
endmodule

bind lgp_driver lgp_driver_mon #(.CHANNELS(CHANNELS)) i_lgp_driver_mon (.clk_sys, .rst, .paddr, .psel, .penable,
    .pready, .pslverr, .shift_clock, .serial_out, .latch_strobe, .program_mode_sel, .correction_source_sel,
    .output_off_force, .open_led_detect, .overtemp_flag, .sink_output, .dot_correction, .error_flag_n_o,
    .error_flag_n_oe);

// [tb/lgp_host_model.sv]
`timescale 1ns/1ns
module lgp_host_model (
    input  wire logic clk_sys,
    input  wire logic serial_out,
    output logic      shift_clock,
    output logic      serial_in,
    output logic      latch_strobe
);
    initial begin
        shift_clock = 1'b0;
        serial_in = 1'b0;
        latch_strobe = 1'b0;
    end

    // Eight system clocks per shift clock period; the shift clock stands low between frames.
    task automatic frame(input logic [191:0] d, input int n, output logic [191:0] q);
        q = '0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= d[i];
            repeat (4) @(posedge clk_sys);
            q = {q[190:0], serial_out};
            shift_clock <= 1'b1;
            repeat (4) @(posedge clk_sys);
            shift_clock <= 1'b0;
        end
        // No pull on the data line, so the last bit is not left standing.
        serial_in <= ~d[0];
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic pulse_latch();
        latch_strobe <= 1'b1;
        repeat (4) @(posedge clk_sys);
        latch_strobe <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule

// [tb/led_grayscale_pwm_driver_ctrl_test.sv]
`timescale 1ns/1ns
module led_grayscale_pwm_driver_ctrl_test;
    logic         clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic         shift_clock, serial_in, serial_out, latch_strobe, program_mode_sel, program_level;
    logic         correction_source_sel, output_off_force, pwm_ref_clock, overtemp_flag;
    logic         error_flag_n_o, error_flag_n_oe;
    logic [15:0]  open_led_detect, sink_output;
    logic [95:0]  dot_correction;
    logic [191:0] q;
    int           n_mismatch = 0;
    int           cmp_count = 0;
    localparam logic [191:0] GS_V = {{13{12'h800}}, 12'hfff, 12'h001, 12'h000};
    localparam logic [95:0]  DC_V = 96'h0123_4567_89ab_cdef_0246_8ace;

    lgp_driver i_lgp_driver (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .irq, .shift_clock, .serial_in, .serial_out, .latch_strobe, .program_mode_sel,
        .program_level, .correction_source_sel, .output_off_force, .pwm_ref_clock, .open_led_detect,
        .overtemp_flag, .sink_output, .dot_correction, .error_flag_n_o, .error_flag_n_oe);
    lgp_host_model i_lgp_host_model (.clk_sys, .serial_out, .shift_clock, .serial_in, .latch_strobe);

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk(input logic [191:0] seen, input logic [191:0] exp, input string m);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        psel <= 1'b1;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic pwm(input int n);
        repeat (n) begin
            pwm_ref_clock <= 1'b1;
            tick(3);
            pwm_ref_clock <= 1'b0;
            tick(3);
        end
    endtask

    task automatic force_off();
        output_off_force <= 1'b1;
        tick(5);
        chk(sink_output, '0, "forced off");
        output_off_force <= 1'b0;
        tick(5);
    endtask

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {program_mode_sel, program_level, correction_source_sel, output_off_force} = '0;
        {pwm_ref_clock, overtemp_flag, open_led_detect} = '0;
        tick(2);
        rst <= 1'b0;
        tick(3);
        chk(dot_correction, {16{6'h3f}}, "eeprom default");
        apb(12'h020, 1'b0, '0);
        chk({rd, er}, 33'h1, "unmapped read");
        i_lgp_host_model.frame(GS_V, 192, q);
        chk(sink_output, '0, "held before latch");
        i_lgp_host_model.pulse_latch();
        force_off();
        chk(sink_output, 16'hfffe, "count zero");
        pwm(1);
        chk(sink_output, 16'hfffc, "count one");
        pwm(4097);
        chk(sink_output, '0, "count end");
        apb(12'h00c, 1'b0, '0);
        chk(rd[12:0], 13'h1000, "counter stops");
        chk(irq, 1'b0, "masked irq");
        apb(12'h004, 1'b1, 32'h0000_0008);
        chk(irq, 1'b1, "irq raised");
        apb(12'h000, 1'b1, 32'h0000_0008);
        chk(irq, 1'b0, "irq cleared");
        apb(12'h000, 1'b0, '0);
        chk(rd[3:0], 4'h4, "latch event left pending");
        force_off();
        apb(12'h00c, 1'b0, '0);
        chk(rd[12:0], 13'h0000, "counter cleared");
        apb(12'h008, 1'b1, 32'h0000_0001);
        tick(2);
        chk(sink_output, '0, "soft off");
        apb(12'h008, 1'b0, '0);
        chk(rd, 32'h0000_0001, "ctrl readback");
        apb(12'h008, 1'b1, 32'h0000_0000);
        tick(2);
        chk(sink_output, 16'hfffe, "soft off released");
        program_mode_sel <= 1'b1;
        correction_source_sel <= 1'b1;
        tick(4);
        chk(dot_correction, '0, "register source");
        i_lgp_host_model.frame(DC_V, 96, q);
        chk(dot_correction, '0, "dc held");
        i_lgp_host_model.pulse_latch();
        chk(dot_correction, DC_V, "dc latched");
        force_off();
        chk(sink_output, 16'hfffe, "gs kept in dc mode");
        correction_source_sel <= 1'b0;
        tick(6);
        chk(dot_correction, {16{6'h3f}}, "eeprom source");
        program_level <= 1'b1;
        correction_source_sel <= 1'b1;
        tick(6);
        program_level <= 1'b0;
        tick(3);
        correction_source_sel <= 1'b0;
        tick(8);
        chk(dot_correction, DC_V, "eeprom programmed");
        overtemp_flag <= 1'b1;
        tick(5);
        chk(error_flag_n_oe, 1'b1, "overtemp error");
        overtemp_flag <= 1'b0;
        open_led_detect <= 16'ha5a5;
        program_mode_sel <= 1'b0;
        tick(5);
        chk(error_flag_n_oe, 1'b1, "open led error");
        i_lgp_host_model.pulse_latch();
        apb(12'h010, 1'b0, '0);
        chk(rd[15:0], 16'ha5a5, "lod status");
        i_lgp_host_model.frame(GS_V, 192, q);
        chk(q[191:175], {16'ha5a5, 1'b0}, "status shifted out");
        open_led_detect <= '0;
        tick(5);
        chk(error_flag_n_oe, 1'b0, "error released");
        close_out();
    end

    initial begin
        #(40 * 60000);
        n_mismatch++;
        close_out();
    end
endmodule
